// ---- design/sfl_params.svh ----
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH
// ==========================================
// clock and timing
`define SFL_CLK_NS 50
`define SFL_BYTE_PROG_NS 20000
`define SFL_PAGE_PROG_NS 1000000
// ==========================================
// array geometry
`define SFL_ARRAY_BYTES 32768
`define SFL_ADDR_W 15
`define SFL_PAGE_BYTES 256
`define SFL_ERASED 8'hff
// ==========================================
// opcodes
`define SFL_OP_READ_FAST 8'h0b
`define SFL_OP_READ_SLOW 8'h03
`define SFL_OP_READ_DUAL 8'h3b
`define SFL_OP_PROGRAM 8'h02
// ==========================================
// host register map and fields
`define SFL_REG_CTRL 8'h00
`define SFL_REG_DATA 8'h04
`define SFL_REG_STAT 8'h08
`define SFL_CTRL_CS_BIT 0
`define SFL_CTRL_DUAL_BIT 1
`define SFL_STAT_BUSY_BIT 0
`define SFL_HOST_HALF_CYC 8
`endif

// ---- design/sfl_pkg.sv ----
package sfl_pkg;
  // ==========================================
  // device command phases
  typedef enum logic [5:0] {
    SFL_OPC = 6'h01,
    SFL_ADR = 6'h02,
    SFL_DUM = 6'h04,
    SFL_RD = 6'h08,
    SFL_PRG = 6'h10,
    SFL_IGN = 6'h20
  } sfl_cmd_e;
  // ==========================================
  // device program engine
  typedef enum logic [2:0] {
    SFL_P_IDLE = 3'h1,
    SFL_P_WALK = 3'h2,
    SFL_P_WAIT = 3'h4
  } sfl_prog_e;
  // ==========================================
  // host byte engine
  typedef enum logic [2:0] {
    SFL_H_IDLE = 3'h1,
    SFL_H_LOW = 3'h2,
    SFL_H_HIGH = 3'h4
  } sfl_host_e;
endpackage

// ---- design/sfl_spi_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// serial link between host and flash
interface sfl_spi_if;
  logic cs_n;
  logic sck;
  logic mosi_d;
  logic mosi_oe;
  logic so_d;
  logic so_oe;
  logic bidir_d;
  logic bidir_oe;
  logic so_lvl;
  logic sio_lvl;
  // wire levels, pulled high when undriven
  assign so_lvl = so_oe ? so_d : 1'b1;
  assign sio_lvl = bidir_oe ? bidir_d : (mosi_oe ? mosi_d : 1'b1);
  modport device (input cs_n, sck, sio_lvl, output so_d, so_oe, bidir_d, bidir_oe);
  modport host (output cs_n, sck, mosi_d, mosi_oe, input so_lvl, sio_lvl);
endinterface
`default_nettype wire

// ---- design/sfl_device.sv ----
// Overview of operation
// - accept fast and slow single read opcodes
// - host sends opcode, address, optional dummy
// - internal read address counter auto increments
// - single read shifts data MSB first
// - read wraps from last to first location
// - chip select high ends read, floats output
// - dual read needs address plus one dummy
// - dual read drives two bits per clock
// - dual read ends anytime, floats both pins
// - program opcode, address, data into buffer
// - program only with write enable latch set
// - unaligned program data wraps within page
// - buffer keeps last page of bytes
// - program buffered bytes, others keep their contents
// - abort on short address, data, misalignment
// - protected target ignores program command
// - aborted program clears write enable latch
// - busy while programming, latch cleared before end
// - host should poll status for completion
// - report failed bytes in error flag
// - single byte programs faster than page
// - sample rising edge, drive falling edge
// - ignore address bits above the array
// - ignore unknown opcodes and short commands
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sfl_params.svh"
module sfl_device
  import sfl_pkg::*;
#(
  parameter int BYTE_PROG_CYC = `SFL_BYTE_PROG_NS / `SFL_CLK_NS,
  parameter int PAGE_PROG_CYC = `SFL_PAGE_PROG_NS / `SFL_CLK_NS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // serial link
  sfl_spi_if.device spi,
  // status and write enable logic
  input wire logic wel_set_i,
  input wire logic protect_i,
  output logic busy_o,
  output logic write_enable_latch_o,
  output logic program_erase_error_flag_o
);

  // ==========================================
  // elaboration checks
  if (BYTE_PROG_CYC < 1 || PAGE_PROG_CYC < BYTE_PROG_CYC || PAGE_PROG_CYC > 65535) begin : g_chk
    $error("sfl_device: program cycle counts out of range");
  end

  localparam logic [15:0] BYTE_LAST = 16'(BYTE_PROG_CYC - 1);
  localparam logic [15:0] PAGE_LAST = 16'(PAGE_PROG_CYC - 1);

  // ==========================================
  // pin synchronisers
  logic cs_s1, cs_s2, cs_d;
  logic sck_s1, sck_s2, sck_d;
  logic sio_s1, sio_s2;
  logic sck_rise, sck_fall, cs_rise;

  // two flops on every pin
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      sio_s1 <= 1'b1;
      sio_s2 <= 1'b1;
    end else begin
      cs_s1 <= spi.cs_n;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      sck_s1 <= spi.sck;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      sio_s1 <= spi.sio_lvl;
      sio_s2 <= sio_s1;
    end
  end

  // clock edge events, only while selected
  assign sck_rise = sck_s2 & ~sck_d & ~cs_s2;
  assign sck_fall = ~sck_s2 & sck_d & ~cs_s2;
  assign cs_rise = cs_s2 & ~cs_d;

  // ==========================================
  // command front end
  sfl_cmd_e st;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [6:0] shift_in;
  logic [7:0] in_byte;
  logic [7:0] cur_op;
  logic [`SFL_ADDR_W-1:0] addr;
  logic byte_done;
  sfl_prog_e pst;

  assign in_byte = {shift_in, sio_s2};
  assign byte_done = sck_rise && bit_cnt == 3'h7;

  // opcode, address and dummy sequencing
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || cs_s2) begin
      st <= SFL_OPC;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (sck_rise) begin
      shift_in <= in_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        case (st)
          SFL_OPC: begin
            cur_op <= in_byte;
            if (pst != SFL_P_IDLE) begin
              st <= SFL_IGN;
            end else if (in_byte == `SFL_OP_READ_FAST || in_byte == `SFL_OP_READ_SLOW ||
                         in_byte == `SFL_OP_READ_DUAL || in_byte == `SFL_OP_PROGRAM) begin
              st <= SFL_ADR;
            end else begin
              st <= SFL_IGN;
            end
          end
          SFL_ADR: begin
            addr <= {addr[6:0], in_byte};
            byte_cnt <= byte_cnt + 2'h1;
            if (byte_cnt == 2'h2) begin
              if (cur_op == `SFL_OP_PROGRAM) begin
                st <= SFL_PRG;
              end else if (cur_op == `SFL_OP_READ_SLOW) begin
                st <= SFL_RD;
              end else begin
                st <= SFL_DUM;
              end
            end
          end
          SFL_DUM: st <= SFL_RD;
          default: st <= st;
        endcase
      end
    end
  end

  // ==========================================
  // array and read data path
  // array starts erased, one driver only
  logic [7:0] mem [0:`SFL_ARRAY_BYTES-1] = '{default: `SFL_ERASED};
  logic [`SFL_ADDR_W-1:0] rd_ptr;
  logic [`SFL_ADDR_W-1:0] rd_start;
  logic [7:0] out_sh;
  logic [2:0] out_cnt;
  logic rd_enter;
  logic dual;

  assign dual = cur_op == `SFL_OP_READ_DUAL;
  assign rd_start = (st == SFL_DUM) ? addr : {addr[6:0], in_byte};
  assign rd_enter = byte_done && (st == SFL_DUM ||
    (st == SFL_ADR && byte_cnt == 2'h2 && cur_op == `SFL_OP_READ_SLOW));

  // first byte fetched as the last header bit arrives
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || cs_s2) begin
      spi.so_oe <= 1'b0;
      spi.bidir_oe <= 1'b0;
      spi.so_d <= 1'b0;
      spi.bidir_d <= 1'b0;
      out_cnt <= 3'h0;
    end else if (rd_enter) begin
      out_sh <= mem[rd_start];
      rd_ptr <= rd_start + 15'h1;
      out_cnt <= 3'h0;
    end else if (sck_fall && st == SFL_RD) begin
      spi.so_d <= out_sh[7];
      spi.so_oe <= 1'b1;
      out_cnt <= out_cnt + 3'h1;
      if (dual) begin
        spi.bidir_d <= out_sh[6];
        spi.bidir_oe <= 1'b1;
        out_sh <= {out_sh[5:0], 2'h0};
      end else begin
        out_sh <= {out_sh[6:0], 1'b0};
      end
      if ((dual && out_cnt == 3'h3) || (!dual && out_cnt == 3'h7)) begin
        out_sh <= mem[rd_ptr];
        rd_ptr <= rd_ptr + 15'h1;
        out_cnt <= 3'h0;
      end
    end
  end

  // ==========================================
  // page buffer
  logic [7:0] pbuf [0:`SFL_PAGE_BYTES-1];
  logic [`SFL_PAGE_BYTES-1:0] pflag;
  logic [7:0] wptr;
  logic [8:0] nbytes;
  logic [6:0] page;

  // collect program data, wrap inside the page
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pflag <= '0;
      nbytes <= 9'h0;
      wptr <= 8'h0;
    end else if (byte_done && st == SFL_ADR && byte_cnt == 2'h2 &&
                 cur_op == `SFL_OP_PROGRAM) begin
      wptr <= in_byte;
      page <= addr[6:0];
      pflag <= '0;
      nbytes <= 9'h0;
    end else if (byte_done && st == SFL_PRG) begin
      pbuf[wptr] <= in_byte;
      pflag[wptr] <= 1'b1;
      wptr <= wptr + 8'h1;
      if (nbytes != 9'h100) begin
        nbytes <= nbytes + 9'h1;
      end
    end
  end

  // ==========================================
  // program engine
  logic start_ok;
  logic abort_clr;
  logic wel_drop;
  logic single;
  logic [7:0] pidx;
  logic [15:0] timer;
  logic [7:0] merged;

  assign start_ok = cs_rise && st == SFL_PRG && bit_cnt == 3'h0 && nbytes != 9'h0 &&
                    write_enable_latch_o && !protect_i;
  assign abort_clr = cs_rise && cur_op == `SFL_OP_PROGRAM &&
                     (st == SFL_ADR || st == SFL_PRG) && !start_ok;
  assign wel_drop = pst == SFL_P_WALK && pidx == 8'hff;
  assign merged = mem[{page, pidx}] & pbuf[pidx];

  // walk the page, then wait out the self-timed cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pst <= SFL_P_IDLE;
      busy_o <= 1'b0;
      program_erase_error_flag_o <= 1'b0;
      pidx <= 8'h0;
      timer <= 16'h0;
      single <= 1'b0;
    end else begin
      case (pst)
        SFL_P_IDLE: begin
          if (start_ok) begin
            pst <= SFL_P_WALK;
            busy_o <= 1'b1;
            program_erase_error_flag_o <= 1'b0;
            pidx <= 8'h0;
            single <= nbytes == 9'h1;
          end
        end
        SFL_P_WALK: begin
          if (pflag[pidx]) begin
            mem[{page, pidx}] <= merged;
            if (merged != pbuf[pidx]) begin
              program_erase_error_flag_o <= 1'b1;
            end
          end
          pidx <= pidx + 8'h1;
          if (pidx == 8'hff) begin
            pst <= SFL_P_WAIT;
            timer <= single ? BYTE_LAST : PAGE_LAST;
          end
        end
        SFL_P_WAIT: begin
          timer <= timer - 16'h1;
          if (timer == 16'h0) begin
            pst <= SFL_P_IDLE;
            busy_o <= 1'b0;
          end
        end
        default: pst <= SFL_P_IDLE;
      endcase
    end
  end

  // write enable latch, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (wel_set_i) begin
      write_enable_latch_o <= 1'b1;
    end else if (abort_clr || wel_drop) begin
      write_enable_latch_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- design/sfl_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sfl_params.svh"
module sfl_host
  import sfl_pkg::*;
#(
  parameter int HALF_CYC = `SFL_HOST_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial link
  sfl_spi_if.host spi
);

  // ==========================================
  // elaboration checks
  if (HALF_CYC < 5 || HALF_CYC > 65535) begin : g_chk
    $error("sfl_host: half period too short for the device synchronisers");
  end

  localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

  sfl_host_e st;
  logic cs_on, dual;
  logic [7:0] tx, rx;
  logic [3:0] cnt;
  logic [15:0] div;
  logic tick, acc, launch;

  assign acc = psel_i & penable_i & ~pready_o;
  assign launch = acc && pwrite_i && paddr_i == `SFL_REG_DATA && st == SFL_H_IDLE;
  assign tick = st != SFL_H_IDLE && div == HALF_LAST;

  // ==========================================
  // apb registers, one wait state
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
      cs_on <= 1'b0;
      dual <= 1'b0;
    end else begin
      pready_o <= acc;
      pslverr_o <= 1'b0;
      if (acc) begin
        prdata_o <= 32'h0;
        if (paddr_i == `SFL_REG_CTRL) begin
          if (pwrite_i && st == SFL_H_IDLE) begin
            cs_on <= pwdata_i[`SFL_CTRL_CS_BIT];
            dual <= pwdata_i[`SFL_CTRL_DUAL_BIT];
          end
          prdata_o[`SFL_CTRL_CS_BIT] <= cs_on;
          prdata_o[`SFL_CTRL_DUAL_BIT] <= dual;
        end else if (paddr_i == `SFL_REG_DATA) begin
          prdata_o[7:0] <= rx;
        end else if (paddr_i == `SFL_REG_STAT) begin
          prdata_o[`SFL_STAT_BUSY_BIT] <= st != SFL_H_IDLE;
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // pins follow control register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      spi.cs_n <= 1'b1;
      spi.mosi_oe <= 1'b0;
    end else begin
      spi.cs_n <= ~cs_on;
      spi.mosi_oe <= cs_on & ~dual;
    end
  end

  // ==========================================
  // byte engine, mode 0
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st <= SFL_H_IDLE;
      spi.sck <= 1'b0;
      spi.mosi_d <= 1'b0;
      div <= 16'h0;
      cnt <= 4'h0;
      tx <= 8'h0;
      rx <= 8'h0;
    end else begin
      div <= (tick || st == SFL_H_IDLE) ? 16'h0 : div + 16'h1;
      case (st)
        SFL_H_IDLE: begin
          if (launch) begin
            st <= SFL_H_LOW;
            tx <= pwdata_i[7:0];
            spi.mosi_d <= pwdata_i[7];
            cnt <= dual ? 4'h4 : 4'h8;
          end
        end
        SFL_H_LOW: begin
          if (tick) begin
            spi.sck <= 1'b1;
            rx <= dual ? {rx[5:0], spi.so_lvl, spi.sio_lvl} : {rx[6:0], spi.so_lvl};
            cnt <= cnt - 4'h1;
            st <= SFL_H_HIGH;
          end
        end
        SFL_H_HIGH: begin
          if (tick) begin
            spi.sck <= 1'b0;
            if (cnt == 4'h0) begin
              st <= SFL_H_IDLE;
            end else begin
              tx <= {tx[6:0], 1'b0};
              spi.mosi_d <= tx[6];
              st <= SFL_H_LOW;
            end
          end
        end
        default: st <= SFL_H_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- sim/sfl_link_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// link and status checker
module sfl_link_props #(
  parameter int BYTE_PROG_CYC = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // link wires
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi_oe,
  input wire logic so_d,
  input wire logic so_oe,
  input wire logic bidir_oe,
  // status side
  input wire logic protect_i,
  input wire logic busy_o,
  input wire logic write_enable_latch_o
);
  int busy_len;
  // length of the current busy run
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !busy_o) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // assertions
  a_cs_float_out: assert property (cs_n [*5] |-> !so_oe && !bidir_oe)
    else $error("data pin driven while deselected");
  a_out_on_select: assert property ($rose(so_oe) |-> !cs_n)
    else $error("output enabled without select");
  a_out_on_fall: assert property (so_oe && $past(so_oe) && $changed(so_d) |-> !sck)
    else $error("output changed while clock high");
  a_no_contention: assert property (!(bidir_oe && mosi_oe))
    else $error("both ends drive the bidir pin");
  a_busy_needs_wel: assert property ($rose(busy_o) |-> $past(write_enable_latch_o))
    else $error("program started without write enable");
  a_busy_unprot: assert property ($rose(busy_o) |-> !$past(protect_i))
    else $error("program started on protected target");
  a_busy_after_cs: assert property ($rose(busy_o) |-> cs_n && $past(cs_n, 3))
    else $error("program started before select release");
  a_wel_cleared: assert property ($fell(busy_o) |-> !write_enable_latch_o)
    else $error("write enable still set at program end");
  a_prog_time: assert property ($fell(busy_o) |-> busy_len >= 256 + BYTE_PROG_CYC)
    else $error("program cycle too short");
  // main scenarios reached
  c_prog: cover property ($rose(busy_o));
  c_dual: cover property ($rose(bidir_oe));
  c_read_end: cover property ($fell(so_oe));
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sfl_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench import sfl_pkg::*;;
  localparam int BPC = 4;
  localparam int PPC = 20;
  // ==========================================
  // stimulus and observed signals
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wel_set = 1'b0, protect = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, perr, busy, write_enable_latch, err;
  int n_mismatch = 0;
  int num_checks = 0;
  // 20 MHz clock
  always #25 sys_clk_i = ~sys_clk_i;
  // ==========================================
  // both ends and the checker
  sfl_spi_if sfl_spi_if_inst ();
  sfl_host #(.HALF_CYC(6)) sfl_host_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .spi(sfl_spi_if_inst));
  sfl_device #(.BYTE_PROG_CYC(BPC), .PAGE_PROG_CYC(PPC)) sfl_device_inst (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .spi(sfl_spi_if_inst),
    .wel_set_i(wel_set), .protect_i(protect), .busy_o(busy),
    .write_enable_latch_o(write_enable_latch), .program_erase_error_flag_o(err));
  sfl_link_props #(.BYTE_PROG_CYC(BPC)) sfl_link_props_inst (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .cs_n(sfl_spi_if_inst.cs_n), .sck(sfl_spi_if_inst.sck),
    .mosi_oe(sfl_spi_if_inst.mosi_oe), .so_d(sfl_spi_if_inst.so_d),
    .so_oe(sfl_spi_if_inst.so_oe), .bidir_oe(sfl_spi_if_inst.bidir_oe),
    .protect_i(protect), .busy_o(busy), .write_enable_latch_o(write_enable_latch));
  // ==========================================
  // verdict
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // a wait ran out
  task automatic tmo;
    n_mismatch++;
    close_out();
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) tmo();
    rd_q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // send one link byte and poll until done
  task automatic sb(input logic [7:0] b);
    int i;
    apb(1'b1, `SFL_REG_DATA, {24'h0, b});
    i = 0;
    do begin
      apb(1'b0, `SFL_REG_STAT, 32'h0);
      i++;
    end while (rd_q[0] !== 1'b0 && i < 100);
    if (rd_q[0] !== 1'b0) tmo();
  endtask
  // select, opcode and address (n < 0 cuts the last byte)
  task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int n);
    apb(1'b1, `SFL_REG_CTRL, 32'h1);
    sb(op);
    sb(a[23:16]);
    sb(a[15:8]);
    if (n >= 0) sb(a[7:0]);
  endtask
  // read three bytes and compare
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [23:0] e);
    hdr(op, a, 0);
    // dual: release the bidir pin first, dummy as two four-clock halves
    if (op == `SFL_OP_READ_DUAL) begin
      apb(1'b1, `SFL_REG_CTRL, 32'h3);
      sb(8'h00);
      sb(8'h00);
    end else if (op != `SFL_OP_READ_SLOW) begin
      sb(8'h00);
    end
    for (int k = 0; k < 3; k++) begin
      sb(8'h00);
      apb(1'b0, `SFL_REG_DATA, 32'h0);
      `CHK(rd_q[7:0], e[23 - 8 * k -: 8])
    end
    apb(1'b1, `SFL_REG_CTRL, 32'h0);
    repeat (6) @(posedge sys_clk_i);
  endtask
  // program n bytes, measure the busy run
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n,
      input logic we, input logic pr, input int len_x);
    int i;
    int len;
    protect <= pr;
    if (we) begin
      @(posedge sys_clk_i);
      wel_set <= 1'b1;
      @(posedge sys_clk_i);
      wel_set <= 1'b0;
    end
    hdr(op, a, n);
    for (i = 0; i < n; i++) sb(i[7:0] ^ {i[8], 7'h00});
    apb(1'b1, `SFL_REG_CTRL, 32'h0);
    len = 0;
    for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge sys_clk_i);
    while (busy === 1'b1 && len < 2000) begin
      len++;
      @(posedge sys_clk_i);
    end
    `CHK(len, len_x)
    if (op == `SFL_OP_PROGRAM) `CHK(write_enable_latch, 1'b0)
    protect <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask
  // ==========================================
  // scenarios
  task automatic t_abort;
    prog(`SFL_OP_PROGRAM, 24'h000040, 1, 1'b0, 1'b0, 0);
    prog(`SFL_OP_PROGRAM, 24'h000020, -1, 1'b1, 1'b0, 0);
    prog(`SFL_OP_PROGRAM, 24'h000020, 0, 1'b1, 1'b0, 0);
    prog(`SFL_OP_PROGRAM, 24'h000030, 1, 1'b1, 1'b1, 0);
    prog(8'h5a, 24'h000050, 1, 1'b1, 1'b0, 0);
    rd(`SFL_OP_READ_FAST, 24'h000020, 24'hffffff);
    rd(`SFL_OP_READ_SLOW, 24'h000030, 24'hffffff);
    rd(`SFL_OP_READ_SLOW, 24'h000040, 24'hffffff);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK(perr, 1'b1)
    $display("test abort done");
  endtask
  task automatic t_prog;
    prog(`SFL_OP_PROGRAM, 24'h0000fe, 3, 1'b1, 1'b0, 256 + PPC);
    rd(`SFL_OP_READ_SLOW, 24'h0000fe, 24'h0001ff);
    rd(`SFL_OP_READ_FAST, 24'h000000, 24'h02ffff);
    prog(`SFL_OP_PROGRAM, 24'h000060, 1, 1'b1, 1'b0, 256 + BPC);
    `CHK(err, 1'b0)
    prog(`SFL_OP_PROGRAM, 24'h0000fd, 2, 1'b1, 1'b0, 256 + PPC);
    `CHK(err, 1'b1)
    $display("test program done");
  endtask
  task automatic t_wrap;
    rd(`SFL_OP_READ_DUAL, 24'hff7fff, 24'hff02ff);
    rd(`SFL_OP_READ_FAST, 24'h807ffe, 24'hffff02);
    prog(`SFL_OP_PROGRAM, 24'h000100, 258, 1'b1, 1'b0, 256 + PPC);
    `CHK(err, 1'b0)
    rd(`SFL_OP_READ_SLOW, 24'h000100, 24'h808102);
    $display("test wrap done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_abort();
    t_prog();
    t_wrap();
    close_out();
  end
  initial begin
    repeat (95000) @(posedge sys_clk_i);
    tmo();
  end
endmodule
`default_nettype wire
